/* File: inc/adc_glue_defines.svh */
// Named constants for the converter end and the controller end.
// Assumes a single 100 MHz clock shared by both ends.
`ifndef ADC_GLUE_DEFINES_SVH
`define ADC_GLUE_DEFINES_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_FREQ_MHZ 100
`define REF_STARTUP_MS 15
`define REF_STARTUP_CYCLES (`REF_STARTUP_MS * 1000 * `CLK_FREQ_MHZ)
`define SETTLE_1X 7'd100
`define SETTLE_2X 7'd13
`define CONV_RESET_CYCLES 32'd4
`define RD_CAPTURE 2'd2
`define RD_LAST 2'd3
`define OSR_1X_LAST 3'd7
`define OSR_2X_LAST 3'd3
`define IO_ADDR_A15 1'b1

// ---------------------------------------------------------------
// Controller register map
// ---------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_DATA 8'h08
`define REG_IRQ_STAT 8'h0c
`define REG_IRQ_MASK 8'h10
`define CTRL_WAKE 0
`define CTRL_DBL 1
`define CTRL_DEPTH_LSB 2
`define CTRL_DEPTH_MSB 4
`define IRQ_SAMPLE 0
`define IRQ_SETTLED 1

`endif

/* File: inc/adc_glue_pkg.sv */
// Types shared by the converter end, the controller end and the link.
// Assumes nothing beyond the defines header.
package adc_glue_pkg;
   typedef logic [15:0] sample_t;
   typedef enum logic [2:0] {ST_ASLEEP, ST_REF_WAIT, ST_RESET, ST_SETTLE, ST_RUN} ctl_state_t;
endpackage : adc_glue_pkg

/* File: inc/adc_link_if.sv */
// Pin-level link between the converter and its controller.
// Assumes one shared clock; dout is driven continuously and dout_oe only flags reads.
`timescale 1ns/1ns
interface adc_link_if;
   import adc_glue_pkg::*;
   logic sleep_request_n;
   logic double_rate_select;
   logic [2:0] buffer_depth_select;
   logic conv_reset;
   logic read_strobe_n;
   logic select_n;
   sample_t dout;
   logic dout_oe;
   logic sample_ready_strobe;

   modport converter (
      input sleep_request_n,
      input double_rate_select,
      input buffer_depth_select,
      input conv_reset,
      input read_strobe_n,
      input select_n,
      output dout,
      output dout_oe,
      output sample_ready_strobe
   );

   modport controller (
      output sleep_request_n,
      output double_rate_select,
      output buffer_depth_select,
      output conv_reset,
      output read_strobe_n,
      output select_n,
      input dout,
      input dout_oe,
      input sample_ready_strobe
   );
endinterface : adc_link_if

/* File: design/adc_converter.sv */
// Converter end: sleep, reference start-up, decimation and output buffer.
// Assumes link inputs synchronous to clk; analog_code is the sampled input.
`timescale 1ns/1ns
`include "adc_glue_defines.svh"
module adc_converter #(
   parameter int REF_CYCLES = `REF_STARTUP_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire adc_glue_pkg::sample_t analog_code,
   adc_link_if.converter link
);
   import adc_glue_pkg::*;

   logic [31:0] ref_cnt_q, ref_cnt_d;
   logic ref_ok_q, ref_ok_d;
   logic [2:0] dec_q, dec_d;
   logic [3:0] fill_q, fill_d;
   logic [3:0] wr_ptr_q, wr_ptr_d;
   logic [3:0] rd_ptr_q, rd_ptr_d;
   logic rd_prev_q, rd_prev_d;
   logic strobe_q, strobe_d;
   logic oe_q, oe_d;
   sample_t dout_q, dout_d;
   sample_t mem [16];
   logic mem_we;
   logic buffered;
   logic [3:0] depth_words;
   logic [2:0] dec_last;

   // ---------------------------------------------------------------
   // Conversion and buffer
   // ---------------------------------------------------------------
   always_comb
   begin
      buffered = |link.buffer_depth_select;
      depth_words = {link.buffer_depth_select, 1'b0};
      dec_last = link.double_rate_select ? `OSR_2X_LAST : `OSR_1X_LAST;
      ref_cnt_d = ref_cnt_q;
      ref_ok_d = ref_ok_q;
      dec_d = dec_q;
      fill_d = fill_q;
      wr_ptr_d = wr_ptr_q;
      rd_ptr_d = rd_ptr_q;
      strobe_d = 1'b0;
      mem_we = 1'b0;
      rd_prev_d = link.read_strobe_n;
      if (!link.sleep_request_n)
      begin
         // Everything off, reference included
         ref_cnt_d = 32'd0;
         ref_ok_d = 1'b0;
         dec_d = 3'h0;
         fill_d = 4'h0;
         wr_ptr_d = 4'h0;
         rd_ptr_d = 4'h0;
      end
      else if (!ref_ok_q)
      begin
         if (ref_cnt_q == 32'(REF_CYCLES - 1))
         begin
            ref_ok_d = 1'b1;
         end
         ref_cnt_d = ref_cnt_q + 32'd1;
      end
      else if (link.conv_reset)
      begin
         dec_d = 3'h0;
         fill_d = 4'h0;
         wr_ptr_d = 4'h0;
         rd_ptr_d = 4'h0;
      end
      else
      begin
         if (dec_q == dec_last)
         begin
            dec_d = 3'h0;
            mem_we = 1'b1;
            wr_ptr_d = wr_ptr_q + 4'h1;
            if (!buffered)
            begin
               rd_ptr_d = wr_ptr_q;
               strobe_d = 1'b1;
            end
            else if (fill_q == depth_words - 4'h1)
            begin
               fill_d = 4'h0;
               strobe_d = 1'b1;
            end
            else
            begin
               fill_d = fill_q + 4'h1;
            end
         end
         else
         begin
            dec_d = dec_q + 3'h1;
         end
         // Buffered words advance when the read strobe returns high
         if (buffered && !rd_prev_q && link.read_strobe_n)
         begin
            rd_ptr_d = rd_ptr_q + 4'h1;
         end
      end
      oe_d = link.sleep_request_n && !link.select_n && !link.read_strobe_n;
      dout_d = mem[rd_ptr_d];
   end

   always_ff @(posedge clk)
   begin
      if (mem_we)
      begin
         mem[wr_ptr_q] <= analog_code;
      end
      if (rst)
      begin
         ref_cnt_q <= 32'd0;
         ref_ok_q <= 1'b0;
         dec_q <= 3'h0;
         fill_q <= 4'h0;
         wr_ptr_q <= 4'h0;
         rd_ptr_q <= 4'h0;
         rd_prev_q <= 1'b1;
         strobe_q <= 1'b0;
         oe_q <= 1'b0;
         dout_q <= 16'h0000;
      end
      else
      begin
         ref_cnt_q <= ref_cnt_d;
         ref_ok_q <= ref_ok_d;
         dec_q <= dec_d;
         fill_q <= fill_d;
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         rd_prev_q <= rd_prev_d;
         strobe_q <= strobe_d;
         oe_q <= oe_d;
         dout_q <= dout_d;
      end
   end

   assign link.sample_ready_strobe = strobe_q;
   assign link.dout_oe = oe_q;
   assign link.dout = dout_q;
endmodule : adc_converter

/* File: design/adc_controller.sv */
// Controller end: APB registers, sleep exit sequencing and sample readback.
// Assumes one clock shared with the converter and an APB master.
// Operation
// - Sleep low shuts converter and reference down
// - Sleep line held high when unused
// - Stop converter clock while asleep (clk here keeps running)
// - Reset converter after wake with buffer
// - Wait reference start-up after releasing sleep
// - Then wait 100 ready strobes before use
// - Rate select low: oversampling ratio eight
// - Rate select high: ratio four, double rate
// - Double rate still drives all sixteen bits
// - Double rate settles in 13 strobes
// - Drive rate select actively, never float
// - Read strobe and select from host port
// - Buffered converter kept permanently selected
// - Ready strobe is interrupt starting reads
// - Read strobe is NAND of read, space
// - Select is NAND of strobe and A15 (here NAND of I/O space and A15)
// - Any depth bit high enables buffer
`timescale 1ns/1ns
`include "adc_glue_defines.svh"
module adc_controller #(
   parameter int REF_CYCLES = `REF_STARTUP_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output adc_glue_pkg::ctl_state_t seq_state,
   adc_link_if.controller link
);
   import adc_glue_pkg::*;

   // ---------------------------------------------------------------
   // Register bus
   // ---------------------------------------------------------------
   logic ctrl_wake_q, ctrl_wake_d;
   logic ctrl_dbl_q, ctrl_dbl_d;
   logic [2:0] ctrl_depth_q, ctrl_depth_d;
   logic [1:0] irq_stat_q, irq_stat_d;
   logic [1:0] irq_mask_q, irq_mask_d;
   sample_t sample_q, sample_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic irq_q, irq_d;
   logic wr_en;
   logic [1:0] events;

   // Sequencer and read engine
   ctl_state_t state_q, state_d;
   logic [31:0] cnt_q, cnt_d;
   logic [6:0] settle_q, settle_d;
   logic [6:0] settle_last;
   logic dbl_q, dbl_d;
   logic [2:0] depth_q, depth_d;
   logic sleep_n_q, reset_q;
   logic settled_ev;
   logic rd_busy_q, rd_busy_d;
   logic [3:0] words_q, words_d;
   logic [1:0] phase_q, phase_d;
   logic rd_n_q, rd_n_d;
   logic cs_n_q, cs_n_d;
   logic host_rw, host_io_space;
   logic capture;

   always_comb
   begin
      wr_en = psel && penable && pwrite && pready_q;
      ctrl_wake_d = ctrl_wake_q;
      ctrl_dbl_d = ctrl_dbl_q;
      ctrl_depth_d = ctrl_depth_q;
      irq_mask_d = irq_mask_q;
      irq_stat_d = irq_stat_q;
      if (wr_en && paddr == `REG_CTRL)
      begin
         ctrl_wake_d = pwdata[`CTRL_WAKE];
         ctrl_dbl_d = pwdata[`CTRL_DBL];
         ctrl_depth_d = pwdata[`CTRL_DEPTH_MSB:`CTRL_DEPTH_LSB];
      end
      if (wr_en && paddr == `REG_IRQ_MASK)
      begin
         irq_mask_d = pwdata[1:0];
      end
      if (wr_en && paddr == `REG_IRQ_STAT)
      begin
         irq_stat_d = irq_stat_q & ~pwdata[1:0];
      end
      // A new event outranks a clear in the same cycle
      irq_stat_d = irq_stat_d | events;
      irq_d = |(irq_stat_d & irq_mask_d);
      pready_d = psel && !penable;
      pslverr_d = 1'b0;
      prdata_d = prdata_q;
      if (psel && !penable)
      begin
         case (paddr)
            `REG_CTRL: prdata_d = {27'h0, ctrl_depth_q, ctrl_dbl_q, ctrl_wake_q};
            `REG_STATUS: prdata_d = {25'h0, rd_busy_q, dbl_q, depth_q == 3'h0,
                                     state_q == ST_RUN, 3'(state_q)};
            `REG_DATA: prdata_d = {16'h0000, sample_q};
            `REG_IRQ_STAT: prdata_d = {30'h0, irq_stat_q};
            `REG_IRQ_MASK: prdata_d = {30'h0, irq_mask_q};
            default:
            begin
               prdata_d = 32'h0000_0000;
               pslverr_d = 1'b1;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Sleep exit sequencer
   // ---------------------------------------------------------------
   always_comb
   begin
      settle_last = dbl_q ? (`SETTLE_2X - 7'd1) : (`SETTLE_1X - 7'd1);
      state_d = state_q;
      cnt_d = cnt_q;
      settle_d = (state_q == ST_SETTLE) ? settle_q : 7'd0;
      dbl_d = dbl_q;
      depth_d = depth_q;
      settled_ev = 1'b0;
      case (state_q)
         ST_ASLEEP:
         begin
            cnt_d = 32'd0;
            dbl_d = ctrl_dbl_q;
            depth_d = ctrl_depth_q;
            if (ctrl_wake_q)
            begin
               state_d = ST_REF_WAIT;
            end
         end
         ST_REF_WAIT:
         begin
            if (cnt_q == 32'(REF_CYCLES - 1))
            begin
               cnt_d = 32'd0;
               state_d = (depth_q != 3'h0) ? ST_RESET : ST_SETTLE;
            end
            else
            begin
               cnt_d = cnt_q + 32'd1;
            end
         end
         ST_RESET:
         begin
            if (cnt_q == `CONV_RESET_CYCLES - 32'd1)
            begin
               cnt_d = 32'd0;
               state_d = ST_SETTLE;
            end
            else
            begin
               cnt_d = cnt_q + 32'd1;
            end
         end
         ST_SETTLE:
         begin
            if (link.sample_ready_strobe)
            begin
               if (settle_q == settle_last)
               begin
                  state_d = ST_RUN;
                  settled_ev = 1'b1;
               end
               else
               begin
                  settle_d = settle_q + 7'd1;
               end
            end
         end
         ST_RUN:
         begin
            state_d = ST_RUN;
         end
         default:
         begin
            state_d = ST_ASLEEP;
         end
      endcase
      if (state_q != ST_ASLEEP)
      begin
         if (!ctrl_wake_q)
         begin
            state_d = ST_ASLEEP;
            settled_ev = 1'b0;
         end
         else if (ctrl_depth_q != depth_q)
         begin
            // New depth needs a converter reset when the buffer is on
            depth_d = ctrl_depth_q;
            cnt_d = 32'd0;
            settle_d = 7'd0;
            settled_ev = 1'b0;
            if (state_q != ST_REF_WAIT)
            begin
               state_d = (ctrl_depth_q != 3'h0) ? ST_RESET : ST_SETTLE;
            end
         end
         else if (ctrl_dbl_q != dbl_q)
         begin
            dbl_d = ctrl_dbl_q;
            settle_d = 7'd0;
            settled_ev = 1'b0;
            if (state_q == ST_SETTLE || state_q == ST_RUN)
            begin
               state_d = ST_SETTLE;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Readback engine
   // ---------------------------------------------------------------
   always_comb
   begin
      rd_busy_d = rd_busy_q;
      words_d = words_q;
      phase_d = phase_q;
      capture = rd_busy_q && phase_q == `RD_CAPTURE;
      if (!rd_busy_q)
      begin
         // Ready strobe acts as the host's external interrupt
         if (link.sample_ready_strobe && (state_q == ST_SETTLE || state_q == ST_RUN))
         begin
            rd_busy_d = 1'b1;
            words_d = (depth_q == 3'h0) ? 4'h1 : {depth_q, 1'b0};
            phase_d = 2'h0;
         end
      end
      else if (phase_q == `RD_LAST)
      begin
         phase_d = 2'h0;
         words_d = words_q - 4'h1;
         if (words_q == 4'h1)
         begin
            rd_busy_d = 1'b0;
         end
      end
      else
      begin
         phase_d = phase_q + 2'h1;
      end
      if (state_d == ST_ASLEEP || state_d == ST_RESET)
      begin
         rd_busy_d = 1'b0;
      end
      host_rw = phase_d <= `RD_CAPTURE;
      host_io_space = rd_busy_d;
      rd_n_d = !(host_rw && host_io_space);
      cs_n_d = (depth_d != 3'h0) ? 1'b0 : !(host_io_space && `IO_ADDR_A15);
      // Words read while settling are drained but not kept
      sample_d = (capture && state_q == ST_RUN) ? link.dout : sample_q;
      events = {settled_ev, capture && state_q == ST_RUN};
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctrl_wake_q <= 1'b0;
         ctrl_dbl_q <= 1'b0;
         ctrl_depth_q <= 3'h0;
         irq_stat_q <= 2'h0;
         irq_mask_q <= 2'h0;
         sample_q <= 16'h0000;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         irq_q <= 1'b0;
         state_q <= ST_ASLEEP;
         cnt_q <= 32'd0;
         settle_q <= 7'd0;
         dbl_q <= 1'b0;
         depth_q <= 3'h0;
         sleep_n_q <= 1'b0;
         reset_q <= 1'b0;
         rd_busy_q <= 1'b0;
         words_q <= 4'h0;
         phase_q <= 2'h0;
         rd_n_q <= 1'b1;
         cs_n_q <= 1'b1;
      end
      else
      begin
         ctrl_wake_q <= ctrl_wake_d;
         ctrl_dbl_q <= ctrl_dbl_d;
         ctrl_depth_q <= ctrl_depth_d;
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= irq_mask_d;
         sample_q <= sample_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         irq_q <= irq_d;
         state_q <= state_d;
         cnt_q <= cnt_d;
         settle_q <= settle_d;
         dbl_q <= dbl_d;
         depth_q <= depth_d;
         sleep_n_q <= state_d != ST_ASLEEP;
         reset_q <= state_d == ST_RESET;
         rd_busy_q <= rd_busy_d;
         words_q <= words_d;
         phase_q <= phase_d;
         rd_n_q <= rd_n_d;
         cs_n_q <= cs_n_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;
   assign seq_state = state_q;
   assign link.sleep_request_n = sleep_n_q;
   assign link.double_rate_select = dbl_q;
   assign link.buffer_depth_select = depth_q;
   assign link.conv_reset = reset_q;
   assign link.read_strobe_n = rd_n_q;
   assign link.select_n = cs_n_q;
endmodule : adc_controller

/* File: test/adc_glue_properties.sv */
// Concurrent checks on the link between converter and controller.
// Assumes one clock, sync active-high reset, instantiated beside the link.
`timescale 1ns/1ns
module adc_glue_properties #(
   parameter int REF_CYCLES = 20
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic sleep_request_n,
   input wire logic double_rate_select,
   input wire logic [2:0] buffer_depth_select,
   input wire logic conv_reset,
   input wire logic read_strobe_n,
   input wire logic select_n,
   input wire adc_glue_pkg::sample_t dout,
   input wire logic dout_oe,
   input wire logic sample_ready_strobe
);
   import adc_glue_pkg::*;
   localparam int WAKE_MAX = REF_CYCLES + 40;
   logic [7:0] gap_q, gap_d, age_q, age_d, period;
   logic [15:0] wake_q, wake_d;
   logic [4:0] mode_q, mode_now;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // -----------------------------------------
   // Strobe spacing helpers
   // -----------------------------------------
   // Spacing is judged only after the mode has been steady long enough
   always_comb
   begin
      mode_now = {sleep_request_n, double_rate_select, buffer_depth_select};
      period = (double_rate_select ? 8'h04 : 8'h08) *
               (buffer_depth_select == 3'h0 ? 8'h01 : {4'h0, buffer_depth_select, 1'b0});
      gap_d = sample_ready_strobe ? 8'h01 : (gap_q == 8'hff ? gap_q : gap_q + 8'h01);
      age_d = (mode_now != mode_q || conv_reset) ? 8'h00 :
              (age_q == 8'hff ? age_q : age_q + 8'h01);
      wake_d = !sleep_request_n ? 16'h0000 : (wake_q == 16'hffff ? wake_q : wake_q + 16'h0001);
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         gap_q <= 8'h00;
         age_q <= 8'h00;
         wake_q <= 16'h0000;
         mode_q <= 5'h00;
      end
      else
      begin
         gap_q <= gap_d;
         age_q <= age_d;
         wake_q <= wake_d;
         mode_q <= mode_now;
      end
   end
   // -----------------------------------------
   // Assertions
   // -----------------------------------------
   a_sleep_quiet: assert property (!sleep_request_n [*4] |->
      !sample_ready_strobe && !dout_oe) else $error("converter active while asleep");
   a_wake_reset: assert property ($rose(sleep_request_n) && buffer_depth_select != 3'h0
      |-> ##[1:WAKE_MAX] conv_reset) else $error("no reset after buffered wake");
   a_ref_wait: assert property (conv_reset |->
      wake_q >= 16'(REF_CYCLES - 4)) else $error("reset before reference start-up");
   a_reset_len: assert property ($rose(conv_reset) |->
      conv_reset [*4] ##1 !conv_reset) else $error("converter reset width wrong");
   // A sleep or converter reset may cut a word short; it then rises with them
   a_read_low: assert property ($fell(read_strobe_n) |-> ##3 read_strobe_n)
      else $error("read strobe low too long");
   a_read_shape: assert property ($rose(read_strobe_n) && sleep_request_n && !conv_reset |->
      $past(read_strobe_n, 2) == 1'b0 &&
      $past(read_strobe_n, 3) == 1'b0 &&
      $past(read_strobe_n, 4)) else $error("read strobe shape wrong");
   a_sel_cover: assert property (!read_strobe_n |-> !select_n)
      else $error("read strobe without select");
   a_oe_answer: assert property (!select_n && !read_strobe_n |=> dout_oe)
      else $error("output not driven during read");
   a_ready_pulse: assert property ($rose(sample_ready_strobe) |=>
      $fell(sample_ready_strobe)) else $error("ready strobe not one cycle");
   a_osr_normal: assert property (sample_ready_strobe && !double_rate_select
      && age_q == 8'hff |-> gap_q == period) else $error("normal rate spacing wrong");
   a_osr_double: assert property (sample_ready_strobe && double_rate_select
      && age_q == 8'hff |-> gap_q == period) else $error("double rate spacing wrong");
   c_conv_reset: cover property ($rose(conv_reset));
   c_double_ready: cover property (sample_ready_strobe && double_rate_select);
   c_buffered_read: cover property (!read_strobe_n && buffer_depth_select != 3'h0);
endmodule : adc_glue_properties

/* File: test/testbench.sv */
// Self-checking bench: converter and controller joined by the link.
// Assumes a shortened reference start-up and an APB master modelled here.
`timescale 1ns/1ns
`include "adc_glue_defines.svh"
module testbench;
   import adc_glue_pkg::*;
   typedef struct {logic [31:0] data; logic [31:0] mask; logic err;} exp_t;
   localparam int REF = 20;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, prev;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0] depth;
   sample_t analog;
   ctl_state_t seq_state;
   exp_t exp_q[$];
   exp_t ent;
   int n;
   int num_errors = 0;
   int n_compared = 0;
   adc_link_if link ();
   adc_converter #(.REF_CYCLES(REF)) i_adc_converter (.clk(clk), .rst(rst),
      .analog_code(analog), .link(link));
   adc_controller #(.REF_CYCLES(REF)) i_adc_controller (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .seq_state(seq_state), .link(link));
   adc_glue_properties #(.REF_CYCLES(REF)) i_adc_glue_properties (.clk(clk), .rst(rst),
      .sleep_request_n(link.sleep_request_n), .double_rate_select(link.double_rate_select),
      .buffer_depth_select(link.buffer_depth_select), .conv_reset(link.conv_reset),
      .read_strobe_n(link.read_strobe_n), .select_n(link.select_n), .dout(link.dout),
      .dout_oe(link.dout_oe), .sample_ready_strobe(link.sample_ready_strobe));
   // -----------------------------------------
   // Reporting
   // -----------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic give_verdict;
      $display("Compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict
   // -----------------------------------------
   // Drivers
   // -----------------------------------------
   // Reads pass the expected word in d; writes expect nothing back (mask 0)
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic e);
      exp_q.push_back('{d & m, m, e});
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   // Counts ready strobes seen while settling, until running again
   task automatic wait_run(output int cnt);
      cnt = 0;
      for (int i = 0; i < 20000; i++)
      begin
         @(posedge clk);
         if (seq_state === ST_SETTLE && link.sample_ready_strobe === 1'b1) cnt++;
         if (i > 3 && seq_state === ST_RUN) break;
      end
   endtask : wait_run
   always @(posedge clk)
      if (psel && penable && pready === 1'b1)
      begin
         ent = exp_q.pop_front();
         check("prdata", prdata & ent.mask, ent.data);
         check("pslverr", {31'h0, pslverr}, {31'h0, ent.err});
      end
   // -----------------------------------------
   // Clock, watchdog and tests
   // -----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      repeat (60000) @(posedge clk);
      num_errors++;
      $display("[ERR] watchdog expected finish seen hang");
      give_verdict();
   end
   initial
   begin
      {rst, psel, penable, pwrite, paddr, pwdata, analog} = {1'b1, 59'h0};
      void'($urandom(11));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(1'b0, `REG_CTRL, 32'h0, 32'hffffffff, 1'b0);
      apb(1'b0, `REG_STATUS, 32'h0, 32'h7, 1'b0);
      apb(1'b0, `REG_IRQ_STAT, 32'h0, 32'hffffffff, 1'b0);
      apb(1'b0, `REG_IRQ_MASK, 32'h0, 32'hffffffff, 1'b0);
      apb(1'b0, 8'h14, 32'h0, 32'hffffffff, 1'b1);
      apb(1'b1, 8'h40, 32'h1, 32'h0, 1'b1);
      check("sleep_at_reset", {31'h0, link.sleep_request_n}, 32'h0);
      // Wake at normal rate, unbuffered
      analog <= sample_t'($urandom);
      apb(1'b1, `REG_IRQ_MASK, 32'h3, 32'h0, 1'b0);
      apb(1'b1, `REG_CTRL, 32'h1, 32'h0, 1'b0);
      wait_run(n);
      check("settle_1x", {31'h0, n >= 100 && n <= 101}, 32'h1);
      repeat (40) @(posedge clk);
      check("irq_on", {31'h0, irq}, 32'h1);
      apb(1'b0, `REG_DATA, {16'h0, analog}, 32'hffff, 1'b0);
      apb(1'b1, `REG_IRQ_MASK, 32'h0, 32'h0, 1'b0);
      repeat (2) @(posedge clk);
      check("irq_masked", {31'h0, irq}, 32'h0);
      // Double rate, top bits set so all sixteen must travel
      analog <= sample_t'($urandom) | 16'hc001;
      apb(1'b1, `REG_CTRL, 32'h3, 32'h0, 1'b0);
      wait_run(n);
      check("settle_2x", {31'h0, n >= 13 && n <= 14}, 32'h1);
      // Long enough for the spacing checker to judge double rate
      repeat (250) @(posedge clk);
      apb(1'b0, `REG_DATA, {16'h0, analog}, 32'hffff, 1'b0);
      apb(1'b0, `REG_STATUS, 32'h20, 32'h20, 1'b0);
      // Buffered, normal rate again
      depth = 3'($urandom_range(3, 1));
      analog <= sample_t'($urandom);
      apb(1'b1, `REG_CTRL, 32'h1 | {27'h0, depth, 2'h0}, 32'h0, 1'b0);
      wait_run(n);
      check("settle_buf", {31'h0, n >= 100 && n <= 101}, 32'h1);
      while (link.sample_ready_strobe !== 1'b1) @(posedge clk);
      n = 0;
      prev = 1'b1;
      repeat (16 * depth - 2)
      begin
         @(posedge clk);
         if (prev && !link.read_strobe_n) n++;
         prev = link.read_strobe_n;
      end
      check("burst_len", n, 2 * depth);
      apb(1'b0, `REG_DATA, {16'h0, analog}, 32'hffff, 1'b0);
      // Back to sleep; sticky bits clear by writing ones
      apb(1'b1, `REG_CTRL, 32'h0, 32'h0, 1'b0);
      repeat (10) @(posedge clk);
      check("sleep_pin", {31'h0, link.sleep_request_n}, 32'h0);
      // Wake straight into buffered mode: reference wait, converter reset, settling
      analog <= sample_t'($urandom);
      apb(1'b1, `REG_CTRL, 32'h1 | {27'h0, depth, 2'h0}, 32'h0, 1'b0);
      wait_run(n);
      check("settle_wake", {31'h0, n >= 100 && n <= 101}, 32'h1);
      repeat (120) @(posedge clk);
      apb(1'b0, `REG_DATA, {16'h0, analog}, 32'hffff, 1'b0);
      apb(1'b1, `REG_CTRL, 32'h0, 32'h0, 1'b0);
      repeat (10) @(posedge clk);
      check("sleep_again", {31'h0, link.sleep_request_n}, 32'h0);
      apb(1'b1, `REG_IRQ_STAT, 32'h3, 32'h0, 1'b0);
      apb(1'b0, `REG_IRQ_STAT, 32'h0, 32'h3, 1'b0);
      apb(1'b0, `REG_STATUS, 32'h0, 32'h7, 1'b0);
      repeat (5) @(posedge clk);
      give_verdict();
   end
endmodule : testbench
